// ### src/dtm_defs.svh
`ifndef DTM_DEFS_SVH
`define DTM_DEFS_SVH

// ==========================================================================
// Opcodes
`define OPC_CAP_START 8'h8C
`define OPC_TEMP_START 8'h8E
`define OPC_PARTIAL_RESET 8'h8A

// ==========================================================================
// Register addresses
`define ADDR_CAP_CFG 6'h04
`define ADDR_TDIV_CFG 6'h05
`define ADDR_TRES_CFG 6'h06
`define ADDR_EXT_RATIO 6'h0D
`define ADDR_INT_RATIO 6'h0E

// ==========================================================================
// Field positions, capacitance_measure_config
`define CAP_TRIG_LSB 0
`define CAP_TRIG_MSB 1
`define CAP_FLOAT_BIT 2
`define CAP_NCAP_LSB 3
`define CAP_NCAP_MSB 5
`define CAP_FAKE_LSB 6
`define CAP_FAKE_MSB 9
`define CAP_AVG_LSB 10
`define CAP_AVG_MSB 13
`define CAP_CYC_LSB 14
`define CAP_CYC_MSB 23

// Field positions, temperature_divider_config and temperature_resistor_config.
`define TDIV_LSB 0
`define TDIV_MSB 15
`define TSEL_LSB 8
`define TSEL_MSB 14

// ==========================================================================
// Reset values and selection codes
`define CAP_CFG_RESET 24'h00_0001
`define TDIV_CFG_RESET 24'h00_0000
`define TRES_CFG_RESET 24'h00_0000
`define TSEL_EXTERNAL 7'h0C
`define TSEL_INTERNAL 7'h43
`define TRIG_BY_CAP 2'h1
`define TRIG_BY_OPCODE 2'h0

`endif

// ### src/dtm_pkg.sv
`default_nettype none

package dtm_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_CAP_SLOT,
        ST_TEMP_WAIT
    } seq_state_e;

endpackage : dtm_pkg
`default_nettype wire

// ### src/discharge_time_measurement_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtm_defs.svh"

// Summary of operation
// - Result rate falls with cycle time and with fake plus averaging block count.
// - With no fake blocks and no averaging, results refresh after every block.
// - Floating sensors take three discharge measurements per capacitor, one external compensation.
// - Internal compensation slot opens both sensor switches.
// - Internal compensation always; floating mode adds external parasitic compensation.
// - Internal or external temperature resistors chosen by 7-bit field of register 6.
// - External selection places sensor to reference ratio in result address 13.
// - Internal selection places aluminium to polysilicon ratio in result address 14.
// - Trigger source 1 runs temperature after every Nth capacitance conversion.
// - Divider zero runs temperature after every capacitance conversion.
// - Trigger source 0 runs temperature only on the temperature-start opcode.
// - Host starts with capacitance opcode, then polls results or watches interrupt.
// - Discharge measurements are spaced by the cycle time from register 4.
// - A block is one measurement per capacitor, three when floating, plus internal compensation.
module discharge_time_measurement_sequencer
    import dtm_pkg::*;
#(
    parameter int CYC_W = 10,
    parameter int DIV_W = 16
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Host opcodes and configuration writes
    input wire logic opcode_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic cfg_wr_i,
    input wire logic [5:0] cfg_addr_i,
    input wire logic [23:0] cfg_data_i,
    // Host result reads
    input wire logic res_rd_i,
    input wire logic [5:0] res_addr_i,
    output logic [23:0] res_data_o,
    output logic result_ready_irq_n_o,
    // Capacitance converter front end
    output logic cdc_discharge_start_o,
    output logic [2:0] cdc_port_o,
    output logic cdc_internal_comp_o,
    output logic [1:0] cdc_phase_o,
    output logic sensor_switch_high_o,
    output logic sensor_switch_low_o,
    output logic cap_conv_done_o,
    // Resistance converter
    output logic rdc_start_o,
    output logic [6:0] temp_resistor_select_o,
    input wire logic rdc_done_i,
    input wire logic [23:0] rdc_ratio_i
);

    // ======================================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ======================================================================
    // Configuration and result registers
    logic [23:0] cap_cfg_ff, nxt_cap_cfg;
    logic [23:0] tdiv_cfg_ff, nxt_tdiv_cfg;
    logic [23:0] tres_cfg_ff, nxt_tres_cfg;
    logic [23:0] ext_ratio_ff, nxt_ext_ratio;
    logic [23:0] int_ratio_ff, nxt_int_ratio;
    logic [23:0] res_data_ff, nxt_res_data;
    logic irq_n_ff, nxt_irq_n;

    logic [1:0] temp_trigger_source;
    logic floating;
    logic [2:0] last_cap;
    logic [3:0] fake_blocks;
    logic [3:0] avg_blocks;
    logic [CYC_W-1:0] cycle_time_setting;
    logic [DIV_W-1:0] temp_trigger_divider;
    logic [6:0] temp_resistor_select;
    logic [4:0] blocks_per_conv;
    logic conv_done;
    logic temp_done;

    assign temp_trigger_source = cap_cfg_ff[`CAP_TRIG_MSB:`CAP_TRIG_LSB];
    assign floating = cap_cfg_ff[`CAP_FLOAT_BIT];
    assign last_cap = cap_cfg_ff[`CAP_NCAP_MSB:`CAP_NCAP_LSB];
    assign fake_blocks = cap_cfg_ff[`CAP_FAKE_MSB:`CAP_FAKE_LSB];
    assign avg_blocks = cap_cfg_ff[`CAP_AVG_MSB:`CAP_AVG_LSB];
    assign cycle_time_setting = cap_cfg_ff[`CAP_CYC_MSB:`CAP_CYC_LSB];
    assign temp_trigger_divider = tdiv_cfg_ff[`TDIV_MSB:`TDIV_LSB];
    assign temp_resistor_select = tres_cfg_ff[`TSEL_MSB:`TSEL_LSB];
    // Averaging of zero counts as one block, so zero plus zero means one block per result.
    assign blocks_per_conv = 5'(fake_blocks) + ((avg_blocks == 4'h0) ? 5'h01 : 5'(avg_blocks));
    assign temp_done = rdc_done_i;

    always_comb
    begin
        nxt_cap_cfg = cap_cfg_ff;
        nxt_tdiv_cfg = tdiv_cfg_ff;
        nxt_tres_cfg = tres_cfg_ff;
        nxt_ext_ratio = ext_ratio_ff;
        nxt_int_ratio = int_ratio_ff;
        nxt_irq_n = irq_n_ff;
        nxt_res_data = res_data_ff;
        if (cfg_wr_i && cfg_addr_i == `ADDR_CAP_CFG)
            nxt_cap_cfg = cfg_data_i;
        if (cfg_wr_i && cfg_addr_i == `ADDR_TDIV_CFG)
            nxt_tdiv_cfg = cfg_data_i;
        if (cfg_wr_i && cfg_addr_i == `ADDR_TRES_CFG)
            nxt_tres_cfg = cfg_data_i;
        if (temp_done && temp_resistor_select == `TSEL_EXTERNAL)
            nxt_ext_ratio = rdc_ratio_i;
        if (temp_done && temp_resistor_select == `TSEL_INTERNAL)
            nxt_int_ratio = rdc_ratio_i;
        if (res_rd_i)
        begin
            nxt_irq_n = 1'b1;
            case (res_addr_i)
                `ADDR_EXT_RATIO: nxt_res_data = ext_ratio_ff;
                `ADDR_INT_RATIO: nxt_res_data = int_ratio_ff;
                default: nxt_res_data = 24'h00_0000;
            endcase
        end
        // A new result in the same cycle as a read keeps the interrupt asserted.
        if (conv_done || temp_done)
            nxt_irq_n = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            cap_cfg_ff <= `CAP_CFG_RESET;
            tdiv_cfg_ff <= `TDIV_CFG_RESET;
            tres_cfg_ff <= `TRES_CFG_RESET;
            ext_ratio_ff <= 24'h00_0000;
            int_ratio_ff <= 24'h00_0000;
            res_data_ff <= 24'h00_0000;
            irq_n_ff <= 1'b1;
        end
        else
        begin
            cap_cfg_ff <= nxt_cap_cfg;
            tdiv_cfg_ff <= nxt_tdiv_cfg;
            tres_cfg_ff <= nxt_tres_cfg;
            ext_ratio_ff <= nxt_ext_ratio;
            int_ratio_ff <= nxt_int_ratio;
            res_data_ff <= nxt_res_data;
            irq_n_ff <= nxt_irq_n;
        end
    end

    // ======================================================================
    // Measurement sequencer
    seq_state_e state_ff, nxt_state;
    logic [CYC_W-1:0] slot_cnt_ff, nxt_slot_cnt;
    logic [2:0] cap_idx_ff, nxt_cap_idx;
    logic comp_slot_ff, nxt_comp_slot;
    logic [1:0] phase_ff, nxt_phase;
    logic [4:0] blk_cnt_ff, nxt_blk_cnt;
    logic [DIV_W-1:0] div_cnt_ff, nxt_div_cnt;
    logic temp_req_ff, nxt_temp_req;
    logic slot_end;
    logic last_phase;
    logic temp_due;
    logic opc_cap, opc_temp, opc_stop;

    assign opc_cap = opcode_valid_i && opcode_i == `OPC_CAP_START;
    assign opc_temp = opcode_valid_i && opcode_i == `OPC_TEMP_START;
    assign opc_stop = opcode_valid_i && opcode_i == `OPC_PARTIAL_RESET;
    assign slot_end = state_ff == ST_CAP_SLOT && slot_cnt_ff >= cycle_time_setting;
    assign last_phase = !floating || phase_ff == 2'd2;
    assign conv_done = slot_end && comp_slot_ff && blk_cnt_ff + 5'h01 >= blocks_per_conv;
    assign temp_due = (temp_trigger_source == `TRIG_BY_CAP
                       && div_cnt_ff >= temp_trigger_divider)
                      || (temp_trigger_source == `TRIG_BY_OPCODE && temp_req_ff);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_slot_cnt = slot_cnt_ff;
        nxt_cap_idx = cap_idx_ff;
        nxt_comp_slot = comp_slot_ff;
        nxt_phase = phase_ff;
        nxt_blk_cnt = blk_cnt_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_temp_req = temp_req_ff || opc_temp;
        cdc_discharge_start_o = 1'b0;
        rdc_start_o = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                if (opc_cap)
                begin
                    nxt_state = ST_CAP_SLOT;
                    nxt_slot_cnt = '0;
                    nxt_cap_idx = 3'h0;
                    nxt_comp_slot = 1'b0;
                    nxt_phase = 2'd0;
                    nxt_blk_cnt = 5'h00;
                    cdc_discharge_start_o = 1'b1;
                end
                else if (temp_trigger_source == `TRIG_BY_OPCODE && temp_req_ff)
                begin
                    nxt_state = ST_TEMP_WAIT;
                    nxt_temp_req = opc_temp;
                    rdc_start_o = 1'b1;
                end
            end
            ST_CAP_SLOT:
            begin
                nxt_slot_cnt = slot_cnt_ff + CYC_W'(1);
                if (slot_end)
                begin
                    nxt_slot_cnt = '0;
                    cdc_discharge_start_o = 1'b1;
                    if (comp_slot_ff)
                    begin
                        nxt_comp_slot = 1'b0;
                        nxt_cap_idx = 3'h0;
                        nxt_phase = 2'd0;
                        nxt_blk_cnt = blk_cnt_ff + 5'h01;
                        if (conv_done)
                        begin
                            nxt_blk_cnt = 5'h00;
                            if (temp_due)
                            begin
                                cdc_discharge_start_o = 1'b0;
                                rdc_start_o = 1'b1;
                                nxt_state = ST_TEMP_WAIT;
                                nxt_div_cnt = '0;
                                nxt_temp_req = opc_temp;
                            end
                            else if (temp_trigger_source == `TRIG_BY_CAP)
                                nxt_div_cnt = div_cnt_ff + DIV_W'(1);
                        end
                    end
                    else if (!last_phase)
                        nxt_phase = phase_ff + 2'd1;
                    else
                    begin
                        nxt_phase = 2'd0;
                        if (cap_idx_ff == last_cap)
                            nxt_comp_slot = 1'b1;
                        else
                            nxt_cap_idx = cap_idx_ff + 3'h1;
                    end
                end
                if (opc_stop)
                    nxt_state = ST_IDLE;
            end
            ST_TEMP_WAIT:
            begin
                if (temp_done)
                begin
                    nxt_state = ST_CAP_SLOT;
                    nxt_slot_cnt = '0;
                    cdc_discharge_start_o = 1'b1;
                end
                if (opc_stop)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (opc_stop)
            nxt_temp_req = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            state_ff <= ST_IDLE;
            slot_cnt_ff <= '0;
            cap_idx_ff <= 3'h0;
            comp_slot_ff <= 1'b0;
            phase_ff <= 2'd0;
            blk_cnt_ff <= 5'h00;
            div_cnt_ff <= '0;
            temp_req_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            slot_cnt_ff <= nxt_slot_cnt;
            cap_idx_ff <= nxt_cap_idx;
            comp_slot_ff <= nxt_comp_slot;
            phase_ff <= nxt_phase;
            blk_cnt_ff <= nxt_blk_cnt;
            div_cnt_ff <= nxt_div_cnt;
            temp_req_ff <= nxt_temp_req;
        end
    end

    // ======================================================================
    // Front-end switch control
    // Floating phases: high side, low side, then both closed for external compensation.
    assign sensor_switch_high_o = state_ff == ST_CAP_SLOT && !comp_slot_ff
                                  && (!floating || phase_ff != 2'd1);
    assign sensor_switch_low_o = state_ff == ST_CAP_SLOT && !comp_slot_ff
                                 && floating && phase_ff != 2'd0;
    assign cdc_port_o = cap_idx_ff;
    assign cdc_internal_comp_o = comp_slot_ff;
    assign cdc_phase_o = phase_ff;
    assign cap_conv_done_o = conv_done;
    assign temp_resistor_select_o = temp_resistor_select;
    assign res_data_o = res_data_ff;
    assign result_ready_irq_n_o = irq_n_ff;

endmodule : discharge_time_measurement_sequencer
`default_nettype wire

// ### dv/discharge_time_measurement_sequencer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtm_defs.svh"
module dtm_monitor
#(
    parameter int CYC_W = 10
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Host side
    input wire logic opcode_valid_i,
    input wire logic cfg_wr_i,
    input wire logic [5:0] cfg_addr_i,
    input wire logic [23:0] cfg_data_i,
    input wire logic res_rd_i,
    input wire logic [5:0] res_addr_i,
    input wire logic [23:0] res_data_o,
    input wire logic result_ready_irq_n_o,
    // Converter side
    input wire logic cdc_internal_comp_o,
    input wire logic [1:0] cdc_phase_o,
    input wire logic sensor_switch_high_o,
    input wire logic sensor_switch_low_o,
    input wire logic cap_conv_done_o,
    input wire logic [6:0] temp_resistor_select_o,
    input wire logic rdc_done_i,
    input wire logic [23:0] rdc_ratio_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_comp_switch_open: assert property (
        cdc_internal_comp_o |-> !sensor_switch_high_o && !sensor_switch_low_o)
        else $error("sensor switch closed during internal compensation");
    a_both_only_ext: assert property (
        sensor_switch_high_o && sensor_switch_low_o |-> cdc_phase_o == 2'h2)
        else $error("both switches closed outside external compensation");
    a_done_sets_irq: assert property (
        cap_conv_done_o |=> !result_ready_irq_n_o)
        else $error("interrupt not raised after a conversion");
    a_irq_held_low: assert property (
        !result_ready_irq_n_o && !res_rd_i && !opcode_valid_i |=> $stable(result_ready_irq_n_o))
        else $error("interrupt released without a read");
    a_read_clears_irq: assert property (
        res_rd_i && !cap_conv_done_o && !rdc_done_i |=> result_ready_irq_n_o)
        else $error("interrupt kept after a result read");
    a_select_follows: assert property (
        cfg_wr_i && cfg_addr_i == `ADDR_TRES_CFG
        |=> temp_resistor_select_o == $past(cfg_data_i[`TSEL_MSB:`TSEL_LSB]))
        else $error("resistor selection differs from register value");
    a_ext_ratio_read: assert property (
        rdc_done_i && temp_resistor_select_o == `TSEL_EXTERNAL
        ##1 res_rd_i && res_addr_i == `ADDR_EXT_RATIO |=> res_data_o == $past(rdc_ratio_i, 2))
        else $error("external ratio not at its result address");
    a_int_ratio_read: assert property (
        rdc_done_i && temp_resistor_select_o == `TSEL_INTERNAL
        ##1 res_rd_i && res_addr_i == `ADDR_INT_RATIO |=> res_data_o == $past(rdc_ratio_i, 2))
        else $error("internal ratio not at its result address");

    c_conversion: cover property (cap_conv_done_o);
    c_ext_phase: cover property (sensor_switch_high_o && sensor_switch_low_o);
    c_temp_result: cover property (rdc_done_i ##1 res_rd_i);
endmodule : dtm_monitor

bind discharge_time_measurement_sequencer dtm_monitor #(.CYC_W(CYC_W)) u_monitor (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .opcode_valid_i(opcode_valid_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_data_i(cfg_data_i), .res_rd_i(res_rd_i),
    .res_addr_i(res_addr_i), .res_data_o(res_data_o),
    .result_ready_irq_n_o(result_ready_irq_n_o), .cdc_internal_comp_o(cdc_internal_comp_o),
    .cdc_phase_o(cdc_phase_o), .sensor_switch_high_o(sensor_switch_high_o),
    .sensor_switch_low_o(sensor_switch_low_o), .cap_conv_done_o(cap_conv_done_o),
    .temp_resistor_select_o(temp_resistor_select_o), .rdc_done_i(rdc_done_i),
    .rdc_ratio_i(rdc_ratio_i));
`default_nettype wire

// ### dv/rdc_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module rdc_sensor_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Conversion request and result
    input wire logic start_i,
    input wire logic [3:0] lat_i,
    input wire logic [23:0] ratio_i,
    output logic done_o,
    output logic [23:0] ratio_o
);
    logic busy;
    logic [3:0] wait_cnt;

    // Answers lat_i plus one cycles after a start; between answers the result bus keeps toggling.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy <= 1'b0;
            done_o <= 1'b0;
            ratio_o <= 24'h00_0000;
            wait_cnt <= 4'h0;
        end
        else
        begin
            done_o <= busy && wait_cnt == 4'h0;
            ratio_o <= (busy && wait_cnt == 4'h0) ? ratio_i : ~ratio_o;
            busy <= start_i || (busy && wait_cnt != 4'h0);
            wait_cnt <= start_i ? lat_i : wait_cnt - 4'h1;
        end
    end
endmodule : rdc_sensor_model
`default_nettype wire

// ### dv/discharge_time_measurement_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtm_defs.svh"
`define CHK(nm, ex, got) \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
        failures++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end
module discharge_time_measurement_sequencer_tb_top;
    logic clk_i, rst_b_i = 1'b0, op_v = 1'b0, cfg_wr = 1'b0, res_rd = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [5:0] addr = 6'h00;
    logic [23:0] wdata = 24'h00_0000, res_data, rdc_ratio, ratio_set = 24'h00_0000;
    logic [3:0] lat = 4'h0;
    logic [6:0] tsel;
    logic irq_n, conv_done, rdc_start, rdc_done, dstart;
    logic [2:0] port;
    logic [23:0] exp_q[$];
    int failures = 0, n_tests = 0, n_rdc = 0, seed = 9, n_start = 0, p_max = 0;

    discharge_time_measurement_sequencer DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .opcode_valid_i(op_v), .opcode_i(opcode),
        .cfg_wr_i(cfg_wr), .cfg_addr_i(addr), .cfg_data_i(wdata), .res_rd_i(res_rd),
        .res_addr_i(addr), .res_data_o(res_data), .result_ready_irq_n_o(irq_n),
        .cdc_discharge_start_o(dstart), .cdc_port_o(port),
        .cdc_internal_comp_o(), .cdc_phase_o(),
        .sensor_switch_high_o(), .sensor_switch_low_o(), .cap_conv_done_o(conv_done),
        .rdc_start_o(rdc_start), .temp_resistor_select_o(tsel), .rdc_done_i(rdc_done),
        .rdc_ratio_i(rdc_ratio));
    rdc_sensor_model u_rdc (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(rdc_start),
        .lat_i(lat), .ratio_i(ratio_set), .done_o(rdc_done), .ratio_o(rdc_ratio));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Sampled mid-cycle, where the combinational start pulse has settled.
    always @(negedge clk_i)
        if (rdc_start === 1'b1)
            n_rdc++;

    task automatic test_done;
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // ==========================================================================
    // Host requests: kind 0 opcode, 1 configuration write, 2 result read.
    task automatic drive(input int kind, input logic [5:0] a, input logic [23:0] d);
        @(posedge clk_i);
        op_v <= (kind == 0);
        cfg_wr <= (kind == 1);
        res_rd <= (kind == 2);
        opcode <= d[7:0];
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        op_v <= 1'b0;
        cfg_wr <= 1'b0;
        res_rd <= 1'b0;
    endtask : drive

    // Also counts slot starts and the highest capacitor port before the result.
    task automatic wait_conv(output int n);
        n_start = 0;
        p_max = 0;
        for (n = 1; n < 4000; n++)
        begin
            @(negedge clk_i);
            if (conv_done === 1'b1) break;
            n_start += (dstart === 1'b1);
            if (port > p_max)
                p_max = port;
            @(posedge clk_i);
        end
    endtask : wait_conv

    task automatic wait_rdc;
        repeat (300)
        begin
            @(negedge clk_i);
            if (rdc_done === 1'b1) break;
        end
    endtask : wait_rdc

    // Blocks per result times slots per block.
    function automatic int n_slots(int flt, int last, int fake, int avg);
        return (fake + (avg > 0 ? avg : 1)) * ((last + 1) * (flt ? 3 : 1) + 1);
    endfunction : n_slots

    task automatic scen(input int flt, last, fake, avg, trig, input logic [23:0] sel);
        int cyc;
        int n;
        int r0;
        int ns;
        cyc = 1 + ($random(seed) & 3);
        lat <= 4'($random(seed));
        ratio_set <= 24'($random(seed));
        n = (cyc << 14) + (avg << 10) + (fake << 6) + (last << 3) + (flt << 2) + trig;
        drive(1, `ADDR_CAP_CFG, 24'(n));
        drive(1, `ADDR_TDIV_CFG, 24'h00_0000);
        drive(1, `ADDR_TRES_CFG, sel);
        @(negedge clk_i);
        `CHK("select", sel[14:8], tsel)
        r0 = n_rdc;
        drive(0, 6'h00, {16'h0000, `OPC_CAP_START});
        wait_conv(n);
        ns = n_slots(flt, last, fake, avg);
        `CHK("conv_cycles", ns * (cyc + 1), n)
        `CHK("slot_starts", ns - 1, n_start)
        `CHK("last_port", last, p_max)
        if (trig == 0)
        begin
            repeat (20) @(negedge clk_i);
            `CHK("temp_idle", r0, n_rdc)
            `CHK("irq_conv", 1'b0, irq_n)
            drive(0, 6'h00, {16'h0000, `OPC_PARTIAL_RESET});
            drive(0, 6'h00, {16'h0000, `OPC_TEMP_START});
        end
        wait_rdc();
        `CHK("temp_done", 1'b1, rdc_done)
        exp_q.push_back(ratio_set);
        drive(2, sel[14:8] == `TSEL_EXTERNAL ? `ADDR_EXT_RATIO : `ADDR_INT_RATIO, 24'h00_0000);
        @(negedge clk_i);
        `CHK("ratio", exp_q[0], res_data)
        void'(exp_q.pop_front());
        `CHK("irq_read", 1'b1, irq_n)
        drive(2, 6'h00, 24'h00_0000);
        @(negedge clk_i);
        `CHK("unmapped_after", 24'h00_0000, res_data)
        drive(0, 6'h00, {16'h0000, `OPC_PARTIAL_RESET});
        repeat (4) @(posedge clk_i);
    endtask : scen

    initial
    begin
        int r0;
        int n;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("irq_reset", 1'b1, irq_n)
        drive(2, 6'h00, 24'h00_0000);
        @(negedge clk_i);
        `CHK("unmapped", 24'h00_0000, res_data)
        scen(0, 2, 0, 0, 1, 24'h00_0C40);
        scen(1, 1, 2, 4, 0, 24'h00_4340);
        drive(1, `ADDR_CAP_CFG, 24'h00_C001);
        drive(1, `ADDR_TDIV_CFG, 24'h00_0001);
        r0 = n_rdc;
        drive(0, 6'h00, {16'h0000, `OPC_CAP_START});
        repeat (4) wait_conv(n);
        repeat (3) @(negedge clk_i);
        `CHK("temp_per_two", r0 + 2, n_rdc)
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        test_done();
    end
endmodule : discharge_time_measurement_sequencer_tb_top
`default_nettype wire
